/* hw/write_port_consts.svh */
// constants for the byte-lane write port: widths, lane layout, burst and buffer sizes
// assumes inclusion by bare name from the package file; the design files rely on compile order
`ifndef WRITE_PORT_CONSTS_SVH
`define WRITE_PORT_CONSTS_SVH

// ============================================================
// data word and lanes
`define WP_DATA_W 36
`define WP_LANE_W 9
`define WP_LANES 4
`define WP_LANE0_LSB 0
`define WP_LANE1_LSB 9
`define WP_LANE2_LSB 18
`define WP_LANE3_LSB 27

// ============================================================
// addressing and burst
`define WP_ADDR_W 19
`define WP_BEATS 4
`define WP_BEAT_W 2
`define WP_WORD_ADDR_W 21

// ============================================================
// buffering and reset values
`define WP_FIFO_DEPTH 4
`define WP_SYNC_W 2
`define WP_SEL_RESET 1'b1

`endif

/* hw/write_port_pkg.sv */
// types shared by the write port top and its beat buffer, plus the beat carrier
// assumes write_port_consts.svh is on the include path
`include "write_port_consts.svh"

package write_port_pkg;

    // ============================================================
    // burst sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LEAD = 3'b010,
        ST_BEAT = 3'b100
    } seq_state_t;

    // one data beat on its way to the array
    typedef struct packed {
        logic [`WP_WORD_ADDR_W-1:0] addr;
        logic [`WP_LANES-1:0] lane_we;
        logic [`WP_DATA_W-1:0] data;
    } beat_t;

    localparam int BEAT_BITS = $bits(beat_t);

endpackage

`timescale 1ns/100ps

// ============================================================
// valid/ready carrier for beats between the sequencer, buffer and array
interface beat_if #(
    parameter int WIDTH = write_port_pkg::BEAT_BITS
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* hw/beat_fifo.sv */
// small first-in first-out buffer for write beats, valid/ready on both sides
// assumes one clock and an already synchronised active-low reset
`timescale 1ns/100ps

module beat_fifo #(
    parameter int WIDTH = write_port_pkg::BEAT_BITS,
    parameter int DEPTH = `WP_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    beat_if.snk fill,
    beat_if.src drain
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } fifo_state_t;

    fifo_state_t st_reg;
    fifo_state_t st_next;
    logic [WIDTH-1:0] slot [DEPTH];
    logic push;
    logic pop;

    // ============================================================
    // handshakes
    assign fill.ready = (st_reg.count != FULL_COUNT);
    assign drain.valid = (st_reg.count != '0);
    assign drain.data = slot[st_reg.rd_ptr];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    // ============================================================
    // pointers and occupancy
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wr_ptr = (st_reg.wr_ptr == LAST_SLOT) ? '0 : st_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            st_next.rd_ptr = (st_reg.rd_ptr == LAST_SLOT) ? '0 : st_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            st_next.count = st_reg.count + 1'b1;
        end else if (pop && !push) begin
            st_next.count = st_reg.count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // storage needs no reset: nothing reads a slot before it is written
    always_ff @(posedge clk) begin
        if (push) begin
            slot[st_reg.wr_ptr] <= fill.data;
        end
    end

endmodule

/* hw/byte_lane_write_port_x36.sv */
// write data port of a 36-bit, four-beat burst synchronous memory with byte-lane masking
// assumes pins arrive asynchronously; the two clock edges of a period are modelled
// as two consecutive sys_clk samples, true edge first, marked by k_true
`timescale 1ns/100ps

// What this block does
// R1: all four lane selects low on a beat store the whole 36-bit word.
// R2: only lane 0 select low stores bits 8..0, keeps bits 35..9.
// R3: only lane 1 select low stores bits 17..9, keeps the rest.
// R4: only lane 2 select low stores bits 26..18, keeps the rest.
// R5: only lane 3 select low stores bits 35..27, keeps bits 26..0.
// R6: all lane selects high on a beat leave the location untouched.
// R7: selects may change per beat; each beat uses only its own selects.
// R8: each select gates its own 9-bit lane, any mix allowed.
// R9: write starts on a true edge with select low; four beats follow.
// R10: a start on the true edge right after a start is ignored.
module byte_lane_write_port_x36 (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic write_port_select_n,
    input wire logic [`WP_ADDR_W-1:0] write_addr,
    input wire logic [`WP_DATA_W-1:0] write_data,
    input wire logic lane0_write_select_n,
    input wire logic lane1_write_select_n,
    input wire logic lane2_write_select_n,
    input wire logic lane3_write_select_n,
    input wire logic array_hold,
    input wire logic [`WP_WORD_ADDR_W-1:0] peek_addr,
    output logic k_true,
    output logic beat_ready,
    output logic write_busy,
    output logic [`WP_DATA_W-1:0] peek_data
);
    localparam int DEPTH_WORDS = 1 << `WP_WORD_ADDR_W;

    // one synchroniser stage of all pins
    typedef struct packed {
        logic sel_n;
        logic [`WP_ADDR_W-1:0] addr;
        logic [`WP_DATA_W-1:0] data;
        logic [`WP_LANES-1:0] lane_n;
    } pin_sample_t;

    typedef struct packed {
        pin_sample_t sync1;
        pin_sample_t sync2;
        logic phase;
        logic started_last;
        write_port_pkg::seq_state_t seq;
        logic [`WP_BEAT_W-1:0] beat_idx;
        logic [`WP_ADDR_W-1:0] burst_addr;
        logic pend_valid;
        logic [`WP_ADDR_W-1:0] pend_addr;
    } port_state_t;

    localparam pin_sample_t PIN_IDLE = '{
        sel_n: `WP_SEL_RESET,
        addr: '0,
        data: '0,
        lane_n: {`WP_LANES{`WP_SEL_RESET}}
    };

    logic [`WP_SYNC_W-1:0] rst_chain;
    logic rst_sys_n;
    port_state_t st_reg;
    port_state_t st_next;
    pin_sample_t pins_now;
    logic sample_true;
    logic start_ok;
    write_port_pkg::beat_t beat_word;
    logic [`WP_LANES-1:0][`WP_LANE_W-1:0] mem [DEPTH_WORDS];
    logic [`WP_DATA_W-1:0] peek_reg;
    write_port_pkg::beat_t drain_word;

    beat_if #(.WIDTH(write_port_pkg::BEAT_BITS)) fill_bus ();
    beat_if #(.WIDTH(write_port_pkg::BEAT_BITS)) drain_bus ();

    // ============================================================
    // reset release
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_chain <= '0;
        end else begin
            rst_chain <= {rst_chain[`WP_SYNC_W-2:0], 1'b1};
        end
    end
    assign rst_sys_n = rst_chain[`WP_SYNC_W-1];

    // ============================================================
    // pin bundle
    always_comb begin
        pins_now.sel_n = write_port_select_n;
        pins_now.addr = write_addr;
        pins_now.data = write_data;
        pins_now.lane_n = {lane3_write_select_n, lane2_write_select_n,
                           lane1_write_select_n, lane0_write_select_n};
    end

    // the parity of phase also tags the pin value two edges back, so k_true
    // marks the cycle in which a true-edge value must be on the pins
    assign sample_true = !st_reg.phase;
    assign k_true = !st_reg.phase;

    // a start is taken on a true-edge sample unless the previous true edge took one
    assign start_ok = sample_true && !st_reg.sync2.sel_n && !st_reg.started_last; // [R9] [R10]

    // ============================================================
    // beat assembly: each beat carries only its own lane selects
    always_comb begin
        beat_word.addr = {st_reg.burst_addr, st_reg.beat_idx};
        beat_word.lane_we = ~st_reg.sync2.lane_n; // [R7] [R8]
        beat_word.data = st_reg.sync2.data;
    end

    // beats with no lane selected never enter the buffer
    assign fill_bus.valid = (st_reg.seq == write_port_pkg::ST_BEAT)
        && (beat_word.lane_we != '0); // [R6]
    assign fill_bus.data = beat_word;
    assign beat_ready = fill_bus.ready;

    // ============================================================
    // burst sequencer
    always_comb begin
        st_next = st_reg;
        st_next.sync1 = pins_now;
        st_next.sync2 = st_reg.sync1;
        st_next.phase = !st_reg.phase;
        if (sample_true) begin
            st_next.started_last = start_ok; // [R10]
        end
        unique case (st_reg.seq)
            write_port_pkg::ST_IDLE: begin
                if (start_ok) begin
                    st_next.seq = write_port_pkg::ST_LEAD;
                    st_next.burst_addr = st_reg.sync2.addr;
                end
            end
            // the complement sample right after the address carries no data
            write_port_pkg::ST_LEAD: begin
                st_next.seq = write_port_pkg::ST_BEAT;
                st_next.beat_idx = '0;
            end
            write_port_pkg::ST_BEAT: begin
                st_next.beat_idx = st_reg.beat_idx + 1'b1;
                // a start two true edges later overlaps beats 2 and 3
                if (start_ok) begin
                    st_next.pend_valid = 1'b1;
                    st_next.pend_addr = st_reg.sync2.addr;
                end
                if (st_reg.beat_idx == `WP_BEAT_W'(`WP_BEATS - 1)) begin
                    if (st_reg.pend_valid) begin
                        st_next.burst_addr = st_reg.pend_addr;
                        st_next.beat_idx = '0;
                        st_next.pend_valid = 1'b0;
                    end else begin
                        st_next.seq = write_port_pkg::ST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            st_reg.sync1 <= PIN_IDLE;
            st_reg.sync2 <= PIN_IDLE;
            st_reg.phase <= 1'b0;
            st_reg.started_last <= 1'b0;
            st_reg.seq <= write_port_pkg::ST_IDLE;
            st_reg.beat_idx <= '0;
            st_reg.burst_addr <= '0;
            st_reg.pend_valid <= 1'b0;
            st_reg.pend_addr <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ============================================================
    // beat buffer
    beat_fifo #(
        .WIDTH(write_port_pkg::BEAT_BITS),
        .DEPTH(`WP_FIFO_DEPTH)
    ) u_fifo (
        .clk(sys_clk),
        .rst_n(rst_sys_n),
        .fill(fill_bus.snk),
        .drain(drain_bus.src)
    );

    assign drain_bus.ready = !array_hold;
    assign drain_word = drain_bus.data;
    assign write_busy = (st_reg.seq != write_port_pkg::ST_IDLE) || drain_bus.valid;

    // ============================================================
    // array: lane-wise writes, so unselected lanes keep their bits
    always_ff @(posedge sys_clk) begin
        if (drain_bus.valid && drain_bus.ready) begin
            for (int l = 0; l < `WP_LANES; l++) begin
                if (drain_word.lane_we[l]) begin
                    mem[drain_word.addr][l] <=
                        drain_word.data[l*`WP_LANE_W +: `WP_LANE_W]; // [R1] [R2] [R3] [R4] [R5] [R8]
                end
            end
        end
    end

    // observation read of the array, one cycle late
    always_ff @(posedge sys_clk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            peek_reg <= '0;
        end else begin
            peek_reg <= mem[peek_addr];
        end
    end
    assign peek_data = peek_reg;

endmodule

/* test/write_port_assertions.sv */
// checker on the write port top's pins and its k_true, beat_ready and write_busy outputs
// assumes a bind onto the port top; one clock, rst_n active low
`timescale 1ns/100ps

module write_port_assertions (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic write_port_select_n,
    input wire logic array_hold,
    input wire logic k_true,
    input wire logic beat_ready,
    input wire logic write_busy
);
    logic [2:0] since_sel_reg;
    logic [2:0] rel_cnt_reg;

    // ==========
    // helper counters saturate so they never wrap into a false pass
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            since_sel_reg <= 3'h7;
            rel_cnt_reg <= 3'h0;
        end else begin
            since_sel_reg <= 3'h7;
            if (!write_port_select_n) begin
                since_sel_reg <= 3'h0;
            end else if (since_sel_reg != 3'h7) begin
                since_sel_reg <= since_sel_reg + 3'h1;
            end
            rel_cnt_reg <= (rel_cnt_reg == 3'h7) ? rel_cnt_reg : rel_cnt_reg + 3'h1;
        end
    end

    // ==========
    // properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_ktrue_first: assert property ($rose(rst_n) |-> k_true [*3] ##1 !k_true)
        else $error("true sample marker wrong after reset");
    a_ktrue_alt: assert property (rel_cnt_reg == 3'h7 |-> k_true != $past(k_true))
        else $error("true sample marker did not alternate");
    a_start_busy: assert property (!write_port_select_n && k_true && !write_busy
        |-> ##[1:5] write_busy)
        else $error("start did not make the port busy");
    a_busy_origin: assert property ($rose(write_busy) |-> since_sel_reg <= 3'h5)
        else $error("busy without a recent start");
    a_busy_ends: assert property ((write_port_select_n && !array_hold) [*8] ##1
        (write_port_select_n && !array_hold) [*6] |-> !write_busy)
        else $error("burst outlived four beats");
    a_ready_hold: assert property ($fell(beat_ready) |-> $past(array_hold))
        else $error("buffer filled without a stall");
    a_ready_drain: assert property ($rose(beat_ready) |-> !$past(array_hold))
        else $error("buffer drained while stalled");
    a_full_busy: assert property (!beat_ready |-> write_busy)
        else $error("full buffer but not busy");
endmodule

/* test/ctrl_model.sv */
// memory controller model: drives the write pins one true/complement pair at a time
// assumes k_true marks true samples; pins change on falling edges only
`timescale 1ns/100ps

module ctrl_model (
    input wire logic sys_clk,
    input wire logic k_true,
    output logic write_port_select_n,
    output logic [`WP_ADDR_W-1:0] write_addr,
    output logic [`WP_DATA_W-1:0] write_data,
    output logic [3:0] lanes_n
);
    initial begin
        write_port_select_n = 1'b1;
        write_addr = '0;
        write_data = '0;
        lanes_n = 4'hf;
    end

    // unused lines show inverted junk so a stale value never looks valid
    task automatic half(input logic s, input logic [`WP_ADDR_W-1:0] a,
                        input logic [`WP_DATA_W-1:0] d, input logic [3:0] l);
        write_port_select_n <= s;
        write_addr <= s ? ~write_addr : a;
        write_data <= (l == 4'hf) ? ~write_data : d;
        lanes_n <= l;
    endtask

    task automatic pair(input logic s, input logic [`WP_ADDR_W-1:0] a,
                        input logic [`WP_DATA_W-1:0] dt, input logic [3:0] lt,
                        input logic [`WP_DATA_W-1:0] df, input logic [3:0] lf);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (k_true !== 1'b1 && n < 4) begin
            @(negedge sys_clk);
            n++;
        end
        half(s, a, dt, lt);
        @(negedge sys_clk);
        half(1'b1, '0, df, lf);
    endtask
endmodule

/* test/tb.sv */
// self-checking bench for the byte-lane write port
// assumes the consts header and package are compiled first
`timescale 1ns/100ps

bind byte_lane_write_port_x36 write_port_assertions u_write_port_assertions (
    .sys_clk(sys_clk), .rst_n(rst_n), .write_port_select_n(write_port_select_n),
    .array_hold(array_hold), .k_true(k_true), .beat_ready(beat_ready),
    .write_busy(write_busy)
);

module tb;
    logic sys_clk;
    logic rst_n;
    logic array_hold;
    logic [`WP_WORD_ADDR_W-1:0] peek_addr;
    logic sel_n;
    logic [`WP_ADDR_W-1:0] addr;
    logic [`WP_DATA_W-1:0] data;
    logic [3:0] lanes_n;
    logic k_true;
    logic beat_ready;
    logic write_busy;
    logic [`WP_DATA_W-1:0] peek_data;
    logic [`WP_DATA_W-1:0] exp_mem [0:31];
    int miscompares;
    int check_count;

    byte_lane_write_port_x36 u_byte_lane_write_port_x36 (
        .sys_clk(sys_clk), .rst_n(rst_n), .write_port_select_n(sel_n),
        .write_addr(addr), .write_data(data), .lane0_write_select_n(lanes_n[0]),
        .lane1_write_select_n(lanes_n[1]), .lane2_write_select_n(lanes_n[2]),
        .lane3_write_select_n(lanes_n[3]), .array_hold(array_hold),
        .peek_addr(peek_addr), .k_true(k_true), .beat_ready(beat_ready),
        .write_busy(write_busy), .peek_data(peek_data)
    );

    ctrl_model u_ctrl_model (
        .sys_clk(sys_clk), .k_true(k_true), .write_port_select_n(sel_n),
        .write_addr(addr), .write_data(data), .lanes_n(lanes_n)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ==========
    // shared helpers
    function automatic logic [35:0] pat(input logic [8:0] b);
        return {b + 9'h3, b + 9'h2, b + 9'h1, b};
    endfunction

    task automatic cmp(input logic [35:0] got, input logic [35:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic upd(input int w, input logic [35:0] d, input logic [3:0] l);
        for (int i = 0; i < 4; i++) begin
            if (!l[i]) begin
                exp_mem[w][i*`WP_LANE_W +: `WP_LANE_W] = d[i*`WP_LANE_W +: `WP_LANE_W];
            end
        end
    endtask

    task automatic idle;
        u_ctrl_model.pair(1'b1, '0, '0, 4'hf, '0, 4'hf);
    endtask

    task automatic settle;
        int n;
        n = 0;
        @(negedge sys_clk);
        while (write_busy !== 1'b0 && n < 60) begin
            @(negedge sys_clk);
            n++;
        end
        cmp({35'h0, write_busy}, 36'h0, "port stayed busy");
    endtask

    task automatic chk(input int w0);
        for (int k = 0; k < 4; k++) begin
            @(negedge sys_clk);
            peek_addr = `WP_WORD_ADDR_W'(w0 + k);
            @(negedge sys_clk);
            cmp(peek_data, exp_mem[w0 + k], "stored word");
        end
    endtask

    // ==========
    // scenarios
    task automatic t_full; // two full bursts chained without a gap
        u_ctrl_model.pair(1'b0, 19'h1, '0, 4'hf, '0, 4'hf);
        u_ctrl_model.pair(1'b1, '0, pat(9'h10), 4'h0, pat(9'h11), 4'h0);
        u_ctrl_model.pair(1'b0, 19'h3, pat(9'h12), 4'h0, pat(9'h13), 4'h0);
        u_ctrl_model.pair(1'b1, '0, pat(9'h14), 4'h0, pat(9'h15), 4'h0);
        u_ctrl_model.pair(1'b1, '0, pat(9'h16), 4'h0, pat(9'h17), 4'h0);
        idle();
        for (int k = 0; k < 4; k++) begin
            upd(4 + k, pat(9'h10 + 9'(k)), 4'h0);
            upd(12 + k, pat(9'h14 + 9'(k)), 4'h0);
        end
        settle();
        chk(4);
        chk(12);
    endtask

    task automatic t_lanes; // one lane per beat, changing every beat
        u_ctrl_model.pair(1'b0, 19'h1, '0, 4'hf, '0, 4'hf);
        u_ctrl_model.pair(1'b1, '0, pat(9'h20), 4'he, pat(9'h21), 4'hd);
        u_ctrl_model.pair(1'b1, '0, pat(9'h22), 4'hb, pat(9'h23), 4'h7);
        idle();
        upd(4, pat(9'h20), 4'he);
        upd(5, pat(9'h21), 4'hd);
        upd(6, pat(9'h22), 4'hb);
        upd(7, pat(9'h23), 4'h7);
        settle();
        chk(4);
    endtask

    task automatic t_mix; // lane mixes, a masked beat and a start too soon
        u_ctrl_model.pair(1'b0, 19'h3, '0, 4'hf, '0, 4'hf);
        u_ctrl_model.pair(1'b0, 19'h1, pat(9'h30), 4'ha, pat(9'h31), 4'hf);
        u_ctrl_model.pair(1'b1, '0, pat(9'h32), 4'h3, pat(9'h33), 4'h0);
        idle();
        upd(12, pat(9'h30), 4'ha);
        upd(14, pat(9'h32), 4'h3);
        upd(15, pat(9'h33), 4'h0);
        settle();
        chk(12);
        chk(4);
    endtask

    task automatic t_fill; // stalled array fills the buffer, then it drains
        array_hold = 1'b1;
        u_ctrl_model.pair(1'b0, 19'h5, '0, 4'hf, '0, 4'hf);
        u_ctrl_model.pair(1'b1, '0, pat(9'h40), 4'h0, pat(9'h41), 4'h0);
        u_ctrl_model.pair(1'b1, '0, pat(9'h42), 4'h0, pat(9'h43), 4'h0);
        idle();
        repeat (3) @(negedge sys_clk);
        cmp({35'h0, beat_ready}, 36'h0, "buffer not full");
        cmp({35'h0, write_busy}, 36'h1, "not busy while stalled");
        array_hold = 1'b0;
        for (int k = 0; k < 4; k++) begin
            upd(20 + k, pat(9'h40 + 9'(k)), 4'h0);
        end
        settle();
        chk(20);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        array_hold = 1'b0;
        peek_addr = '0;
        miscompares = 0;
        check_count = 0;
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_full();
        t_lanes();
        t_mix();
        t_fill();
        finish_test();
    end

    // the scenarios need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        finish_test();
    end
endmodule
